// >>> src/lgs_top.sv
// AHB-Lite register slave and input synchronisers for the gate input selection
`timescale 1ns/1ns
`default_nettype none
module lgs_top (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Logic inputs from pins
   input wire logic logic_input_zero,
   input wire logic logic_input_one,
   input wire logic logic_input_two,
   input wire logic logic_input_three,
   // Gate outputs
   output logic [7:0] gate_terms,
   output logic gate_out
);
   import lgs_pkg::*;

   lgs_sel_if sif ();

   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [7:0] sel;
   logic wr_pend;
   logic [7:0] wr_addr;

   wire logic addr_phase = hsel & htrans[1] & hready;
   wire logic [7:0] a_ofs = haddr[7:0];
   wire logic wr_sel = wr_pend & (wr_addr == LGS_OFS_SEL);
   // A read right behind a write sees the new value
   wire logic [7:0] cur_sel = wr_sel ? hwdata[7:0] : sel;
   wire logic [31:0] stat_word = (32'(sif.gate_out) << LGS_STAT_GATE_BIT)
      | (32'(sif.terms) << LGS_STAT_TERMS_LSB) | (32'(sync2) << LGS_STAT_IN_LSB);
   wire logic [31:0] rd_mux = (a_ofs == LGS_OFS_SEL) ? {24'h000000, cur_sel} :
      (a_ofs == LGS_OFS_STAT) ? stat_word : 32'h00000000;

   assign hreadyout = 1'b1;
   assign hresp = LGS_HRESP_OKAY;
   assign sif.sel = sel;
   assign sif.in_sync = sync2;
   assign gate_terms = sif.terms;
   assign gate_out = sif.gate_out;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
      end else begin
         sync1 <= {logic_input_three, logic_input_two, logic_input_one, logic_input_zero};
         sync2 <= sync1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= addr_phase & hwrite;
         wr_addr <= a_ofs;
      end
   end

   // Selection register steers the term gating
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel <= LGS_SEL_RESET;
      end else if (wr_sel) begin
         sel <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (addr_phase & ~hwrite) begin
         hrdata <= rd_mux;
      end
   end

   lgs_term_gate u_gate (
      .hclk(hclk),
      .hresetn(hresetn),
      .sif(sif.gate)
   );

   a_sel_write: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && hwrite && a_ofs == LGS_OFS_SEL ##1 1'b1 |=> sel == $past(hwdata[7:0]))
      else $error("selection write not stored");
   a_stat_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && !hwrite && a_ofs == LGS_OFS_STAT |=>
      hrdata[LGS_STAT_GATE_BIT] == $past(sif.gate_out))
      else $error("status gate bit wrong");

   // Bus phase shapes used by the checks below
   sequence s_wr_sel;
      addr_phase && hwrite && a_ofs == LGS_OFS_SEL;
   endsequence
   sequence s_wr_other;
      addr_phase && hwrite && a_ofs != LGS_OFS_SEL;
   endsequence
   sequence s_rd_sel;
      addr_phase && !hwrite && a_ofs == LGS_OFS_SEL;
   endsequence
   sequence s_rd_stat;
      addr_phase && !hwrite && a_ofs == LGS_OFS_STAT;
   endsequence
   sequence s_rd_none;
      addr_phase && !hwrite && a_ofs != LGS_OFS_SEL && a_ofs != LGS_OFS_STAT;
   endsequence
   sequence s_idle;
      !addr_phase;
   endsequence

   a_ready_high: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |->
      hreadyout)
      else $error("slave inserted a wait state");
   a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |->
      hresp == LGS_HRESP_OKAY)
      else $error("slave response not okay");
   a_wr_pend_set: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && hwrite |=>
      wr_pend)
      else $error("write address phase not remembered");
   a_wr_pend_clr: assert property (@(posedge hclk) disable iff (!hresetn)
      !(addr_phase && hwrite) |=>
      !wr_pend)
      else $error("write pending without a write");
   a_idle_no_pend: assert property (@(posedge hclk) disable iff (!hresetn)
      s_idle |=>
      !wr_pend)
      else $error("idle bus left a write pending");
   a_wr_data_phase: assert property (@(posedge hclk) disable iff (!hresetn)
      s_wr_sel |=>
      wr_sel)
      else $error("selection write lost its data phase");
   a_sel_only_byte: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_sel |=>
      sel == $past(hwdata[7:0]))
      else $error("selection byte not taken from write data");
   a_wr_other_kept: assert property (@(posedge hclk) disable iff (!hresetn)
      s_wr_other ##1 1'b1 |=>
      $stable(sel))
      else $error("unmapped write changed the selection");
   a_sel_kept: assert property (@(posedge hclk) disable iff (!hresetn)
      !wr_sel |=>
      $stable(sel))
      else $error("selection changed without a write");
   a_rd_sel_upper: assert property (@(posedge hclk) disable iff (!hresetn)
      s_rd_sel |=>
      hrdata[31:8] == 24'h000000)
      else $error("selection read upper bits not zero");
   a_rd_sel_value: assert property (@(posedge hclk) disable iff (!hresetn)
      s_rd_sel ##0 !wr_sel |=>
      hrdata[7:0] == $past(sel))
      else $error("selection read value wrong");
   a_rd_none_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      s_rd_none |=>
      hrdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_rd_stat_terms: assert property (@(posedge hclk) disable iff (!hresetn)
      s_rd_stat |=>
      hrdata[15:8] == $past(sif.terms))
      else $error("status terms field wrong");
   a_rd_stat_pins: assert property (@(posedge hclk) disable iff (!hresetn)
      s_rd_stat |=>
      hrdata[3:0] == $past(sync2))
      else $error("status input field wrong");
   a_rd_stat_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      s_rd_stat |=>
      hrdata[31:17] == 15'h0000 && hrdata[7:4] == 4'h0)
      else $error("status spare bits not zero");
   a_rd_held: assert property (@(posedge hclk) disable iff (!hresetn)
      !(addr_phase && !hwrite) |=>
      $stable(hrdata))
      else $error("read data changed without a read");
   a_sync_first: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=>
      sync1 == $past({logic_input_three, logic_input_two, logic_input_one, logic_input_zero}))
      else $error("first synchroniser stage wrong");
   a_sync_second: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=>
      sync2 == $past(sync1))
      else $error("second synchroniser stage wrong");
   a_gate_or: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |->
      gate_out == |gate_terms)
      else $error("gate output is not the or of its terms");

   // Each input checked end to end against the selection and the synchronised pin
   genvar b;
   generate
      for (b = 0; b < LGS_NUM_INPUTS; b = b + 1) begin : g_chk
         a_true_path: assert property (@(posedge hclk) disable iff (!hresetn)
            1'b1 |=> gate_terms[2*b+1] == $past(sel[2*b+1] & sync2[b]))
            else $error("true term does not follow its input");
         a_inv_path: assert property (@(posedge hclk) disable iff (!hresetn)
            1'b1 |=> gate_terms[2*b] == $past(sel[2*b] & ~sync2[b]))
            else $error("inverted term does not follow its input");
      end
   endgenerate
endmodule
`default_nettype wire

// >>> src/lgs_pkg.sv
// Constants for the logic cell gate input selection stage
package lgs_pkg;
   localparam int LGS_NUM_INPUTS = 4;
   localparam int LGS_SEL_W = 8;
   localparam int LGS_ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] LGS_OFS_SEL = 8'h00;
   localparam logic [7:0] LGS_OFS_STAT = 8'h04;
   // Selection register field positions
   localparam int LGS_BIT_IN0_INV = 0;
   localparam int LGS_BIT_IN0_TRUE = 1;
   localparam int LGS_BIT_IN1_INV = 2;
   localparam int LGS_BIT_IN1_TRUE = 3;
   localparam int LGS_BIT_IN2_INV = 4;
   localparam int LGS_BIT_IN2_TRUE = 5;
   localparam int LGS_BIT_IN3_INV = 6;
   localparam int LGS_BIT_IN3_TRUE = 7;
   localparam logic [7:0] LGS_SEL_RESET = 8'h00;
   // Status register field positions
   localparam int LGS_STAT_IN_LSB = 0;
   localparam int LGS_STAT_TERMS_LSB = 8;
   localparam int LGS_STAT_GATE_BIT = 16;
   localparam logic [1:0] LGS_HTRANS_NONSEQ = 2'h2;
   localparam logic LGS_HRESP_OKAY = 1'h0;
endpackage

// >>> src/lgs_sel_if.sv
// Carrier between the register side and the term gating stage
`timescale 1ns/1ns
`default_nettype none
interface lgs_sel_if;
   logic [7:0] sel;
   logic [3:0] in_sync;
   logic [7:0] terms;
   logic gate_out;
   modport regs (output sel, output in_sync, input terms, input gate_out);
   modport gate (input sel, input in_sync, output terms, output gate_out);
endinterface
`default_nettype wire

// >>> src/lgs_term_gate.sv
// Per-input polarity gating of the four logic inputs into one gate
`timescale 1ns/1ns
`default_nettype none
module lgs_term_gate (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Selection and terms
   lgs_sel_if.gate sif
);
   import lgs_pkg::*;

   logic [7:0] next_terms;

   genvar k;
   generate
      for (k = 0; k < LGS_NUM_INPUTS; k = k + 1) begin : g_in
         // Odd bit passes the input as is, even bit passes it inverted
         assign next_terms[2*k+1] = sif.sel[2*k+1] & sif.in_sync[k];
         assign next_terms[2*k] = sif.sel[2*k] & ~sif.in_sync[k];
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sif.terms <= 8'h00;
         sif.gate_out <= 1'b0;
      end else begin
         sif.terms <= next_terms;
         sif.gate_out <= |next_terms;
      end
   end

   a_in2_true: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=> sif.terms[LGS_BIT_IN2_TRUE] == $past(sif.sel[5] & sif.in_sync[2]))
      else $error("input two true term wrong");
   a_in2_inv: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=> sif.terms[LGS_BIT_IN2_INV] == $past(sif.sel[4] & ~sif.in_sync[2]))
      else $error("input two inverted term wrong");
   a_in1_true: assert property (@(posedge hclk) disable iff (!hresetn)
      !sif.sel[3] |=> !sif.terms[LGS_BIT_IN1_TRUE])
      else $error("input one true term leaks when disabled");
   a_in1_inv: assert property (@(posedge hclk) disable iff (!hresetn)
      sif.sel[2] && !sif.in_sync[1] |=> sif.terms[LGS_BIT_IN1_INV] && sif.gate_out)
      else $error("input one inverted term missing");
   a_in0_true: assert property (@(posedge hclk) disable iff (!hresetn)
      sif.sel[1] && sif.in_sync[0] |=> sif.terms[LGS_BIT_IN0_TRUE] && sif.gate_out)
      else $error("input zero true term missing");
   a_other_terms: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=> {sif.terms[7:6], sif.terms[0]} == $past({sif.sel[7] & sif.in_sync[3],
         sif.sel[6] & ~sif.in_sync[3], sif.sel[0] & ~sif.in_sync[0]}))
      else $error("input three or inverted zero term wrong");
   a_gate_empty: assert property (@(posedge hclk) disable iff (!hresetn)
      sif.sel == 8'h00 |=> !sif.gate_out)
      else $error("gate active with no term enabled");
endmodule
`default_nettype wire

// >>> testbench/lgs_top_tb.sv
// Self-checking bench for the gate input selection stage
`timescale 1ns/1ns
`default_nettype none
module lgs_top_tb;
   import lgs_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, chk = 0, kind = 0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, e, s;
   logic [3:0] pin = 4'h0;
   logic [7:0] gate_terms;
   logic hreadyout, hresp, gate_out;
   logic [31:0] exp_q[$];
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   always #2 hclk = ~hclk;
   lgs_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .logic_input_zero(pin[0]),
      .logic_input_one(pin[1]), .logic_input_two(pin[2]), .logic_input_three(pin[3]),
      .gate_terms(gate_terms), .gate_out(gate_out));
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Watcher: compares each result against the oldest note
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         test_done;
      end else if (chk && hreadyout === 1'b1) begin
         e = exp_q.pop_front();
         s = kind ? {23'h0, gate_out, gate_terms} : hrdata;
         n_checks++;
         if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", kind ? "gate" : "hrdata", e, s);
         end
      end
   end
   task automatic note(input logic k, input logic [31:0] v);
      exp_q.push_back(v);
      kind <= k;
      chk <= 1'b1;
      @(posedge hclk);
      chk <= 1'b0;
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] v);
      haddr <= {24'h0, a};
      htrans <= LGS_HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wr ? v : 32'h0;
      // Read data is compared at the edge that ends the data phase
      if (!wr) begin
         exp_q.push_back(v);
         kind <= 1'b0;
      end
      chk <= !wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      chk <= 1'b0;
   endtask
   // Write a selection, read it back, drive pins and check the gated terms
   task automatic gate_chk(input logic [7:0] sv);
      logic [7:0] t;
      logic [3:0] p;
      xfer(1'b1, LGS_OFS_SEL, {24'h0, sv});
      xfer(1'b0, LGS_OFS_SEL, {24'h0, sv});
      p = 4'($urandom);
      pin <= p;
      for (int k = 0; k < 4; k++) begin
         t[2*k+1] = sv[2*k+1] & p[k];
         t[2*k] = sv[2*k] & ~p[k];
      end
      repeat (4) @(posedge hclk);
      note(1'b1, {23'h0, |t, t});
      xfer(1'b0, LGS_OFS_STAT, {15'h0, |t, t, 4'h0, p});
   endtask
   initial begin
      void'($urandom(23));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, LGS_OFS_SEL, {24'h0, LGS_SEL_RESET});
      xfer(1'b1, 8'h08, 32'hffffffff);
      xfer(1'b0, 8'h08, 32'h0);
      $display("test reset and unmapped done");
      for (int i = 0; i < 16; i++) gate_chk(8'h1 << i[2:0]);
      $display("test single enables done");
      for (int i = 0; i < 20; i++) gate_chk(8'($urandom));
      $display("test random selections done");
      test_done;
   end
endmodule
`default_nettype wire
